// ---- design/bert_pkg.sv ----
package bert_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PATTERN_SET  = 8'h00;
    localparam logic [7:0] OFS_PAT_LENGTH   = 8'h04;
    localparam logic [7:0] OFS_POLY_TAP     = 8'h08;
    localparam logic [7:0] OFS_PAT_CONTROL  = 8'h0C;
    localparam logic [7:0] OFS_ERR_INSERT   = 8'h10;
    localparam logic [7:0] OFS_STATUS       = 8'h14;
    localparam logic [7:0] OFS_INT_MASK     = 8'h18;
    localparam logic [7:0] OFS_BIT_TALLY    = 8'h1C;
    localparam logic [7:0] OFS_ERR_TALLY    = 8'h20;
    localparam logic [7:0] OFS_PAT_RECEIVE  = 8'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_PRBS_MODE_BIT     = 0;
    localparam int CTL_SYNC_ENABLE_BIT   = 1;
    localparam int CTL_RESYNC_BIT        = 2;
    localparam int CTL_COUNT_LOAD_BIT    = 4;
    localparam int CTL_TRANSMIT_LOAD_BIT = 7;
    localparam int INS_SINGLE_BIT        = 3;
    localparam int ST_IN_SYNC_BIT        = 0;
    localparam int ST_IND_LO_BIT         = 1;
    localparam int ST_IND_HI_BIT         = 2;
    localparam int ST_LOSS_BIT           = 3;
    localparam int ST_ERR_BIT            = 4;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_CONTROL    = 8'h00;
    localparam logic [4:0]  RST_LENGTH     = 5'h1F;
    localparam logic [4:0]  RST_TAP        = 5'h00;
    localparam logic [1:0]  TX_LOAD_EDGES  = 2'h3;
    localparam logic [6:0]  SYNC_BASE_BITS = 7'h22;
    localparam logic [5:0]  LOSS_WINDOW    = 6'h3F;
    localparam logic [2:0]  LOSS_ERRS      = 3'h6;
    localparam logic [7:0]  STICKY_MASK    = 8'h18;

    // Error insertion limits, one in 10^k bits
    localparam logic [23:0] RATE_LIMIT [8] = '{24'h000000, 24'h00000A, 24'h000064,
        24'h0003E8, 24'h002710, 24'h0186A0, 24'h0F4240, 24'h989680};

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ld;
        logic cl;
        logic tck;
        logic rclk;
        logic rdata;
        logic test;
    } bert_pins_t;

    typedef enum logic {
        BERT_HUNT,
        BERT_LOCKED
    } bert_sync_t;

endpackage

// ---- design/bert_core.sv ----
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// Function
// - Transmit load edge copies pattern set register into generator.
// - Programmed MSB leaves transmit data after third transmit clock edge.
// - Transmit load pin ORed with control bit 7 forms load trigger.
// - Pseudorandom polynomials up to 32 bits, programmable length and tap.
// - Repetitive patterns of 1 to 32 bits.
// - First feedback tap always at pattern length minus one.
// - Second feedback tap programmable anywhere.
// - Sync enable and resync control bits govern the synchronizer.
// - Pseudorandom check accepts any stream fitting the polynomial.
// - Sync declared after 34 plus exponent error-free bits.
// - Repetitive check accepts any pattern of the transmitted length.
// - While in sync each deviating bit increments error counter.
// - Separate readable 32-bit bit and error counters.
// - Count load marks end of each integration period.
// - Single error or one in ten to ten million error insertion.
// - Receiver holds sync with error rates up to one in hundred.
// - Transmit and receive run independently on own data clocks.
// - Test input floats interrupt, transmit data and receive loss.
// - Count load edge latches counts into tallies, clears counters.
// - Count load pin ORed with control bit 4 forms count trigger.
// - Active-low open-drain interrupt flags enabled status conditions.
module bert_core
    import bert_pkg::*;
#(
    parameter int PAT_W = 32
) (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins from outside
    input  wire logic        transmit_load,
    input  wire logic        count_load,
    input  wire logic        transmit_clock,
    input  wire logic        receive_clock,
    input  wire logic        receive_data,
    input  wire logic        test_mode,
    // Pins to outside
    output logic             transmit_data_out,
    output logic             transmit_data_oe,
    output logic             receive_loss_out,
    output logic             receive_loss_oe,
    output logic             int_n_out,
    output logic             int_n_oe
);

    localparam int LW = $clog2(PAT_W);

    if (PAT_W < 2 || PAT_W > 32 || (1 << LW) != PAT_W) begin : g_chk
        $error("bert_core: PAT_W must be a power of two from 2 to 32");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    bert_pins_t pins;
    bert_pins_t sy1_ff, sy2_ff, sy3_ff, lvl_ff, lvl_d_ff, rise;

    assign pins = '{ld: transmit_load, cl: count_load, tck: transmit_clock,
                    rclk: receive_clock, rdata: receive_data, test: test_mode};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_ff   <= '0;
            sy2_ff   <= '0;
            sy3_ff   <= '0;
            lvl_ff   <= '0;
            lvl_d_ff <= '0;
        end else if (ce) begin
            sy1_ff   <= pins;
            sy2_ff   <= sy1_ff;
            sy3_ff   <= sy2_ff;
            // Level moves only where stages two and three agree
            lvl_ff   <= (sy2_ff & sy3_ff) | (lvl_ff & (sy2_ff | sy3_ff));
            lvl_d_ff <= lvl_ff;
        end
    end

    assign rise = lvl_ff & ~lvl_d_ff;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [PAT_W-1:0] pat_set_ff;
    logic [LW-1:0]    pat_len_ff;
    logic [LW-1:0]    poly_tap_ff;
    logic [7:0]       ctrl_ff;
    logic [2:0]       err_rate_ff;
    logic             single_req;
    logic [7:0]       int_mask_ff;
    logic [7:0]       sticky_ff;
    logic [31:0]      bit_tally_ff;
    logic [31:0]      err_tally_ff;
    logic [PAT_W-1:0] pat_rx_ff;
    logic [7:0]       status;
    logic             wr_en;
    logic             rd_setup;
    logic             addr_ok;
    logic [31:0]      nxt_prdata;

    function automatic logic map_hit(input logic [7:0] a);
        case (a)
            OFS_PATTERN_SET, OFS_PAT_LENGTH, OFS_POLY_TAP, OFS_PAT_CONTROL,
            OFS_ERR_INSERT, OFS_STATUS, OFS_INT_MASK, OFS_BIT_TALLY,
            OFS_ERR_TALLY, OFS_PAT_RECEIVE: map_hit = 1'b1;
            default: map_hit = 1'b0;
        endcase
    endfunction

    assign addr_ok    = map_hit(paddr);
    assign wr_en      = psel & penable & pwrite & addr_ok & ce;
    assign rd_setup   = psel & ~penable & ~pwrite;
    assign single_req = wr_en && paddr == OFS_ERR_INSERT && pwdata[INS_SINGLE_BIT];
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pat_set_ff  <= '0;
            pat_len_ff  <= RST_LENGTH[LW-1:0];
            poly_tap_ff <= RST_TAP[LW-1:0];
            ctrl_ff     <= RST_CONTROL;
            err_rate_ff <= '0;
            int_mask_ff <= '0;
        end else if (wr_en) begin
            case (paddr)
                OFS_PATTERN_SET: pat_set_ff  <= pwdata[PAT_W-1:0];
                OFS_PAT_LENGTH:  pat_len_ff  <= pwdata[LW-1:0];
                OFS_POLY_TAP:    poly_tap_ff <= pwdata[LW-1:0];
                OFS_PAT_CONTROL: ctrl_ff     <= pwdata[7:0];
                OFS_ERR_INSERT:  err_rate_ff <= pwdata[2:0];
                OFS_INT_MASK:    int_mask_ff <= pwdata[7:0] & STICKY_MASK;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        nxt_prdata = '0;
        case (paddr)
            OFS_PATTERN_SET: nxt_prdata[PAT_W-1:0] = pat_set_ff;
            OFS_PAT_LENGTH:  nxt_prdata[LW-1:0]    = pat_len_ff;
            OFS_POLY_TAP:    nxt_prdata[LW-1:0]    = poly_tap_ff;
            OFS_PAT_CONTROL: nxt_prdata[7:0]       = ctrl_ff;
            OFS_ERR_INSERT:  nxt_prdata[2:0]       = err_rate_ff;
            OFS_STATUS:      nxt_prdata[7:0]       = status;
            OFS_INT_MASK:    nxt_prdata[7:0]       = int_mask_ff;
            OFS_BIT_TALLY:   nxt_prdata            = bit_tally_ff;
            OFS_ERR_TALLY:   nxt_prdata            = err_tally_ff;
            OFS_PAT_RECEIVE: nxt_prdata[PAT_W-1:0] = pat_rx_ff;
            default:         nxt_prdata            = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && rd_setup) begin
            prdata <= nxt_prdata;
        end
    end

    // ----------------------------------------------------------------
    // Transmit generator
    // ----------------------------------------------------------------
    logic             ld_trig, ld_trig_d_ff, tx_load;
    logic [PAT_W-1:0] gen_ff;
    logic [1:0]       tx_dly_ff;
    logic             single_pend_ff;
    logic [23:0]      ins_cnt_ff;
    logic             inject, tx_fb, tx_step, tx_bit_ff;

    assign ld_trig = lvl_ff.ld | ctrl_ff[CTL_TRANSMIT_LOAD_BIT];
    assign tx_load = ld_trig & ~ld_trig_d_ff;
    assign tx_step = rise.tck && tx_dly_ff <= 2'h1;
    assign tx_fb   = ctrl_ff[CTL_PRBS_MODE_BIT] ? gen_ff[pat_len_ff] ^ gen_ff[poly_tap_ff]
                                                : gen_ff[pat_len_ff];
    assign inject  = single_pend_ff |
                     (err_rate_ff != 3'h0 && ins_cnt_ff == RATE_LIMIT[err_rate_ff] - 24'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_trig_d_ff <= 1'b0;
            gen_ff       <= '0;
            tx_dly_ff    <= '0;
            tx_bit_ff    <= 1'b0;
        end else if (ce) begin
            ld_trig_d_ff <= ld_trig;
            if (tx_load) begin
                gen_ff    <= pat_set_ff;
                tx_dly_ff <= TX_LOAD_EDGES;
            end else if (rise.tck) begin
                if (tx_dly_ff != 2'h0) begin
                    tx_dly_ff <= tx_dly_ff - 2'h1;
                end
                if (tx_step) begin
                    tx_bit_ff <= gen_ff[pat_len_ff] ^ inject;
                    gen_ff    <= {gen_ff[PAT_W-2:0], tx_fb};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_pend_ff <= 1'b0;
            ins_cnt_ff     <= '0;
        end else if (ce) begin
            if (single_req) begin
                single_pend_ff <= 1'b1;
            end else if (tx_step && !tx_load) begin
                single_pend_ff <= 1'b0;
            end
            if (err_rate_ff == 3'h0) begin
                ins_cnt_ff <= '0;
            end else if (tx_step && !tx_load) begin
                ins_cnt_ff <= (ins_cnt_ff >= RATE_LIMIT[err_rate_ff] - 24'h1) ? 24'h0
                                                                       : ins_cnt_ff + 24'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive synchronizer
    // ----------------------------------------------------------------
    bert_sync_t       sync_ff;
    logic [PAT_W-1:0] rsr_ff, rsr_nxt, len_msk;
    logic [6:0]       hunt_cnt_ff, sync_thr;
    logic [5:0]       win_cnt_ff;
    logic [2:0]       win_err_ff;
    logic             rx_exp, rx_mis, resync_d_ff, resync_req, sync_en, in_sync;
    logic             got_sync, lost_sync;

    function automatic logic [PAT_W-1:0] len_mask(input logic [LW-1:0] len);
        len_mask = {PAT_W{1'b1}} >> (PAT_W - 1 - int'(len));
    endfunction

    assign in_sync    = sync_ff == BERT_LOCKED;
    assign sync_en    = ctrl_ff[CTL_SYNC_ENABLE_BIT];
    assign resync_req = ctrl_ff[CTL_RESYNC_BIT] & ~resync_d_ff;
    assign rx_exp     = ctrl_ff[CTL_PRBS_MODE_BIT] ? rsr_ff[pat_len_ff] ^ rsr_ff[poly_tap_ff]
                                                   : rsr_ff[pat_len_ff];
    assign rx_mis     = lvl_ff.rdata ^ rx_exp;
    // Flywheel on expected bits once locked
    assign rsr_nxt    = {rsr_ff[PAT_W-2:0], in_sync ? rx_exp : lvl_ff.rdata};
    assign sync_thr   = SYNC_BASE_BITS + 7'(pat_len_ff) + 7'h1;
    assign got_sync   = rise.rclk && sync_en && !in_sync && !rx_mis &&
                        hunt_cnt_ff + 7'h1 >= sync_thr;
    // Drop only at six errors in 64
    assign lost_sync  = rise.rclk && sync_en && in_sync && rx_mis &&
                        win_err_ff == LOSS_ERRS - 3'h1;
    assign len_msk    = len_mask(pat_len_ff);

    // Receive state on receive clock edges, except resync which returns to hunt at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ff     <= BERT_HUNT;
            rsr_ff      <= '0;
            hunt_cnt_ff <= '0;
            win_cnt_ff  <= '0;
            win_err_ff  <= '0;
            resync_d_ff <= 1'b0;
            pat_rx_ff   <= '0;
        end else if (ce) begin
            resync_d_ff <= ctrl_ff[CTL_RESYNC_BIT];
            if (resync_req) begin
                sync_ff     <= BERT_HUNT;
                hunt_cnt_ff <= '0;
            end else if (rise.rclk) begin
                rsr_ff <= rsr_nxt;
                case (sync_ff)
                    BERT_HUNT: begin
                        if (rx_mis) begin
                            hunt_cnt_ff <= '0;
                        end else if (sync_en && hunt_cnt_ff != 7'h7F) begin
                            hunt_cnt_ff <= hunt_cnt_ff + 7'h1;
                        end
                        if (got_sync) begin
                            sync_ff    <= BERT_LOCKED;
                            pat_rx_ff  <= rsr_nxt;
                            win_cnt_ff <= '0;
                            win_err_ff <= '0;
                        end
                    end
                    BERT_LOCKED: begin
                        win_cnt_ff <= win_cnt_ff + 6'h1;
                        if (lost_sync) begin
                            sync_ff     <= BERT_HUNT;
                            hunt_cnt_ff <= '0;
                        end else if (win_cnt_ff == LOSS_WINDOW) begin
                            win_err_ff <= '0;
                        end else if (rx_mis) begin
                            win_err_ff <= win_err_ff + 3'h1;
                        end
                    end
                    default: sync_ff <= BERT_HUNT;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Bit and error counters
    // ----------------------------------------------------------------
    logic [31:0] bit_cnt_ff, err_cnt_ff;
    logic        cl_trig, cl_trig_d_ff, cnt_load;

    assign cl_trig  = lvl_ff.cl | ctrl_ff[CTL_COUNT_LOAD_BIT];
    assign cnt_load = cl_trig & ~cl_trig_d_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cl_trig_d_ff <= 1'b0;
            bit_cnt_ff   <= '0;
            err_cnt_ff   <= '0;
            bit_tally_ff <= '0;
            err_tally_ff <= '0;
        end else if (ce) begin
            cl_trig_d_ff <= cl_trig;
            if (cnt_load) begin
                bit_tally_ff <= bit_cnt_ff;
                err_tally_ff <= err_cnt_ff;
                bit_cnt_ff   <= '0;
                err_cnt_ff   <= '0;
            end else if (rise.rclk) begin
                if (bit_cnt_ff != '1) begin
                    bit_cnt_ff <= bit_cnt_ff + 32'h1;
                end
                if (in_sync && rx_mis && err_cnt_ff != '1) begin
                    err_cnt_ff <= err_cnt_ff + 32'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Status and interrupt
    // ----------------------------------------------------------------
    logic [7:0] sticky_set, sticky_clr;

    assign sticky_set = {3'h0, in_sync && rise.rclk && rx_mis, lost_sync, 3'h0};
    assign sticky_clr = (wr_en && paddr == OFS_STATUS) ? pwdata[7:0] & STICKY_MASK : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_ff <= '0;
        end else if (ce) begin
            // Set wins over clear
            sticky_ff <= (sticky_ff & ~sticky_clr) | sticky_set;
        end
    end

    always_comb begin
        status                 = sticky_ff;
        status[ST_IN_SYNC_BIT] = in_sync;
        status[ST_IND_LO_BIT]  = (rsr_ff & len_msk) == '0;
        status[ST_IND_HI_BIT]  = (rsr_ff & len_msk) == len_msk;
    end

    assign transmit_data_out = tx_bit_ff;
    assign transmit_data_oe  = ~lvl_ff.test;
    assign receive_loss_out  = ~in_sync;
    assign receive_loss_oe   = ~lvl_ff.test;
    // Open-drain low when enabled flag set
    assign int_n_out         = 1'b0;
    assign int_n_oe          = |(sticky_ff & int_mask_ff) & ~lvl_ff.test;

endmodule

// ---- dv/bert_core_sva.sv ----
`timescale 1ns/1ps
module bert_core_chk
    import bert_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        transmit_clock,
    input wire logic        test_mode,
    input wire logic        transmit_data_out,
    input wire logic        transmit_data_oe,
    input wire logic        receive_loss_oe,
    input wire logic        int_n_out,
    input wire logic        int_n_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    property p_ready;
        s_setup ##1 s_access |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access without ready");

    property p_unmapped;
        s_setup ##0 (!pwrite && paddr > OFS_PAT_RECEIVE) ##1 s_access |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

    property p_mapped;
        s_access ##0 (paddr <= OFS_PAT_RECEIVE && paddr[1:0] == 2'h0) |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");

    property p_idle_ok;
        !(psel && penable) |-> !pslverr;
    endproperty
    a_idle_ok: assert property (p_idle_ok) else $error("error outside access");

    property p_rdata_hold;
        !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    property p_float;
        test_mode [*8] |-> !transmit_data_oe && !receive_loss_oe && !int_n_oe;
    endproperty
    a_float: assert property (p_float) else $error("pins driven in test");

    property p_drive;
        !test_mode [*8] |-> transmit_data_oe && receive_loss_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("pins floating");

    property p_int_level;
        int_n_oe |-> !int_n_out;
    endproperty
    a_int_level: assert property (p_int_level) else $error("interrupt not low");

    property p_tx_still;
        $stable(transmit_clock) [*8] |=> $stable(transmit_data_out);
    endproperty
    a_tx_still: assert property (p_tx_still) else $error("tx moved w/o clock");
endmodule

bind bert_core bert_core_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_clock(transmit_clock), .test_mode(test_mode),
    .transmit_data_out(transmit_data_out), .transmit_data_oe(transmit_data_oe),
    .receive_loss_oe(receive_loss_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe)
);

// ---- dv/bert_channel.sv ----
`timescale 1ns/1ps
module bert_channel (
    // Transmit side
    input  wire logic tck,
    input  wire logic tdata,
    input  wire logic tdata_oe,
    // Receive side
    output logic      rclk,
    output logic      rdata
);
    logic last;

    // Half a bit late, receive samples mid-bit
    assign rclk = ~tck;

    always @(tdata or tdata_oe) begin
        if (tdata_oe) begin
            last = tdata;
        end
    end

    // Released line shows inverse of last level
    assign rdata = tdata_oe ? tdata : ~last;
endmodule

// ---- dv/bit_error_rate_tester_test.sv ----
`timescale 1ns/1ps
module bit_error_rate_tester_test;
    import bert_pkg::*;

    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        transmit_load, count_load, transmit_clock, receive_clock, receive_data;
    logic        test_mode, transmit_data_out, transmit_data_oe, receive_loss_out;
    logic        receive_loss_oe, int_n_out, int_n_oe;
    int          bad_count, n_compared;

    bert_core dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .transmit_load(transmit_load),
        .count_load(count_load), .transmit_clock(transmit_clock),
        .receive_clock(receive_clock), .receive_data(receive_data),
        .test_mode(test_mode), .transmit_data_out(transmit_data_out),
        .transmit_data_oe(transmit_data_oe), .receive_loss_out(receive_loss_out),
        .receive_loss_oe(receive_loss_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe)
    );

    bert_channel u_chan (
        .tck(transmit_clock), .tdata(transmit_data_out), .tdata_oe(transmit_data_oe),
        .rclk(receive_clock), .rdata(receive_data)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic results();
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            bad_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Link clock bursts of 16 pclk periods
    task automatic run(input int n);
        repeat (n) begin
            transmit_clock <= 1'b1;
            repeat (8) @(posedge pclk);
            transmit_clock <= 1'b0;
            repeat (8) @(posedge pclk);
        end
    endtask

    task automatic cl_pin();
        count_load <= 1'b1;
        repeat (6) @(posedge pclk);
        count_load <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, OFS_PAT_LENGTH, 32'h0);
        chk("length", {27'h0, RST_LENGTH}, rd);
        apb(1'b0, OFS_PAT_CONTROL, 32'h0);
        chk("control", {24'h0, RST_CONTROL}, rd);
        apb(1'b1, OFS_POLY_TAP, 32'hFFFF_FFF1);
        apb(1'b0, OFS_POLY_TAP, 32'h0);
        chk("tap", 32'h0000_0011, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
    endtask

    task automatic t_tx(input logic pin, input logic [7:0] pat);
        int i;
        apb(1'b1, OFS_PATTERN_SET, {24'h0, pat});
        apb(1'b1, OFS_PAT_LENGTH, 32'h7);
        if (pin) begin
            transmit_load <= 1'b1;
            repeat (6) @(posedge pclk);
            transmit_load <= 1'b0;
            repeat (6) @(posedge pclk);
        end else begin
            apb(1'b1, OFS_PAT_CONTROL, 32'h80);
            apb(1'b1, OFS_PAT_CONTROL, 32'h0);
        end
        for (i = 1; i <= 12; i++) begin
            run(1);
            if (i >= 3) chk("tx bit", 32'(pat[7 - (i - 3) % 8]), 32'(transmit_data_out));
        end
    endtask

    task automatic t_rep();
        apb(1'b1, OFS_PAT_CONTROL, 32'h2);
        run(60);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("rep sync", 32'h1, 32'(rd[ST_IN_SYNC_BIT]));
        chk("indicators", 32'h0, 32'(rd[2:1]));
        chk("loss", 32'h0, 32'(receive_loss_out));
        apb(1'b0, OFS_PAT_RECEIVE, 32'h0);
        chk("rx pattern", 32'h4, $countones(rd[7:0]));
        cl_pin();
        run(20);
        apb(1'b1, OFS_PAT_CONTROL, 32'h12);
        apb(1'b1, OFS_PAT_CONTROL, 32'h2);
        apb(1'b0, OFS_BIT_TALLY, 32'h0);
        chk("bits", 32'h14, rd);
        apb(1'b0, OFS_ERR_TALLY, 32'h0);
        chk("errors", 32'h0, rd);
        apb(1'b1, OFS_INT_MASK, 32'h10);
        chk("int idle", 32'h0, 32'(int_n_oe));
        apb(1'b1, OFS_ERR_INSERT, 32'h8);
        run(20);
        cl_pin();
        apb(1'b0, OFS_BIT_TALLY, 32'h0);
        chk("bits", 32'h14, rd);
        apb(1'b0, OFS_ERR_TALLY, 32'h0);
        chk("errors", 32'h1, rd);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("error flag", 32'h1, 32'(rd[ST_ERR_BIT]));
        chk("int", 32'h1, 32'(int_n_oe));
    endtask

    task automatic t_prbs();
        apb(1'b1, OFS_PATTERN_SET, 32'h0000_001F);
        apb(1'b1, OFS_PAT_LENGTH, 32'h4);
        apb(1'b1, OFS_POLY_TAP, 32'h2);
        apb(1'b1, OFS_PAT_CONTROL, 32'h83);
        apb(1'b1, OFS_PAT_CONTROL, 32'h7);
        apb(1'b1, OFS_PAT_CONTROL, 32'h3);
        run(30);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("prbs early", 32'h0, 32'(rd[ST_IN_SYNC_BIT]));
        chk("loss early", 32'h1, 32'(receive_loss_out));
        run(30);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("prbs sync", 32'h1, 32'(rd[ST_IN_SYNC_BIT]));
    endtask

    task automatic t_test();
        test_mode <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("tx oe", 32'h0, 32'(transmit_data_oe));
        chk("loss oe", 32'h0, 32'(receive_loss_oe));
        chk("int oe", 32'h0, 32'(int_n_oe));
        test_mode <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("tx oe back", 32'h1, 32'(transmit_data_oe));
    endtask

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        transmit_load = 1'b0;
        count_load = 1'b0;
        transmit_clock = 1'b0;
        test_mode = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_tx(1'b0, 8'hB4);
        t_tx(1'b1, 8'h3A);
        t_rep();
        t_prbs();
        t_test();
        results();
    end
endmodule
